/* File: core/sensor_power_sequencer_defs.vh */
// Timing figures and derived cycle counts for the sensor power sequencer
`ifndef SENSOR_POWER_SEQUENCER_DEFS_VH
`define SENSOR_POWER_SEQUENCER_DEFS_VH

// System clock rate
`define CLK_SYS_MHZ 125

// Rail-on step spacing, recommended minimum and documented maximum
`define RAIL_ON_GAP_US 5
`define RAIL_ON_GAP_MAX_US 10
`define RAIL_ON_GAP_CYCLES (`RAIL_ON_GAP_US * `CLK_SYS_MHZ)

// Rail-off step spacing, minimum zero, one cycle used
`define RAIL_OFF_GAP_US 0
`define RAIL_OFF_GAP_CYCLES 1

// Hard reset hold after the clock starts
`define RESET_HOLD_MS 1
`define RESET_HOLD_CYCLES (`RESET_HOLD_MS * 1000 * `CLK_SYS_MHZ)

// Internal initialisation, in reference clocks
`define INIT_REFCLKS 150000

// PLL lock wait after configuration
`define PLL_LOCK_MS 1
`define PLL_LOCK_CYCLES (`PLL_LOCK_MS * 1000 * `CLK_SYS_MHZ)

// Gap between power-down and next power-up
`define OFF_GAP_MS 100
`define OFF_GAP_CYCLES (`OFF_GAP_MS * 1000 * `CLK_SYS_MHZ)

// Wait for the end of the current frame after streaming stops
`define STANDBY_WAIT_MS 50
`define STANDBY_WAIT_CYCLES (`STANDBY_WAIT_MS * 1000 * `CLK_SYS_MHZ)

// Reference clock divider from the system clock (even, at least 2)
`define REFCLK_DIV 6

// Timer width
`define TIMER_W 32

`endif

/* File: core/sync_agree.v */
// Three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ns
module sync_agree (
    input wire clk_sys,
    input wire rst_n,
    input wire pin,
    output reg level
);
    reg meta;
    reg stage2;
    reg stage3;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level <= 1'b0;
        end else begin
            meta <= pin;
            stage2 <= meta;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule

/* File: core/wait_timer.v */
// Loadable down-counter that marks the end of a minimum wait
`timescale 1ns/1ns
module wait_timer #(
    parameter W = 32,
    parameter [W-1:0] RESET_COUNT = 0
) (
    input wire clk_sys,
    input wire rst_n,
    input wire load,
    input wire [W-1:0] load_value,
    input wire tick,
    output wire expired
);
    reg [W-1:0] count;

    assign expired = (count == {W{1'b0}});

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= RESET_COUNT;
        end else if (load) begin
            count <= load_value;
        end else if (tick && !expired) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

/* File: core/sensor_power_sequencer.v */
// Host-side power, reset, configuration and streaming sequencer for an image sensor
`timescale 1ns/1ns
`include "sensor_power_sequencer_defs.vh"
module sensor_power_sequencer #(
    parameter USE_SERIAL_RAIL = 0,
    parameter REFCLK_DIV = `REFCLK_DIV,
    parameter RAIL_ON_GAP_CYCLES = `RAIL_ON_GAP_CYCLES,
    parameter RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
    parameter INIT_REFCLKS = `INIT_REFCLKS,
    parameter PLL_LOCK_CYCLES = `PLL_LOCK_CYCLES,
    parameter STANDBY_WAIT_CYCLES = `STANDBY_WAIT_CYCLES,
    parameter OFF_GAP_CYCLES = `OFF_GAP_CYCLES
) (
    input wire clk_sys,
    input wire rst_n,
    input wire power_up_req,
    input wire power_down_req,
    input wire rails_stable,
    input wire config_done,
    input wire stream_write_ack,
    output reg pll_supply_rail_en,
    output reg analog_supply_rail_en,
    output reg pixel_array_supply_rail_en,
    output reg core_supply_rail_en,
    output reg io_supply_rail_en,
    output reg serial_output_supply_rail_en,
    output reg external_reference_clock,
    output reg sensor_reset_n,
    output reg config_req,
    output reg stream_write_req,
    output reg stream_enable_bit,
    output reg streaming,
    output reg powered_off,
    output reg [4:0] sequence_state
);
    localparam W = `TIMER_W;
    localparam [4:0] S_OFF_GAP = 5'h00;
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_PLL_ON = 5'h02;
    localparam [4:0] S_ANA_ON = 5'h03;
    localparam [4:0] S_CORE_ON = 5'h04;
    localparam [4:0] S_IO_ON = 5'h05;
    localparam [4:0] S_SER_ON = 5'h06;
    localparam [4:0] S_SETTLE = 5'h07;
    localparam [4:0] S_RESET = 5'h08;
    localparam [4:0] S_INIT = 5'h09;
    localparam [4:0] S_CONFIG = 5'h0a;
    localparam [4:0] S_PLL_LOCK = 5'h0b;
    localparam [4:0] S_STREAM_ON = 5'h0c;
    localparam [4:0] S_STREAMING = 5'h0d;
    localparam [4:0] S_STREAM_OFF = 5'h0e;
    localparam [4:0] S_STANDBY = 5'h0f;
    localparam [4:0] S_SER_OFF = 5'h10;
    localparam [4:0] S_IO_OFF = 5'h11;
    localparam [4:0] S_CORE_OFF = 5'h12;
    localparam [4:0] S_ANA_OFF = 5'h13;
    localparam [4:0] S_PLL_OFF = 5'h14;
    localparam integer HALF_DIV = REFCLK_DIV / 2;
    localparam [15:0] HALF_LAST = HALF_DIV[15:0] - 16'h0001;

    reg [4:0] state;
    reg [4:0] next_state;
    reg [W-1:0] timer_value;
    reg timer_tick;
    reg [15:0] div_count;
    reg clock_run;
    reg refclk_rise;
    wire timer_load;
    wire timer_done;
    wire stable;
    wire ramping_up;

    sync_agree u_rails_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin(rails_stable),
        .level(stable)
    );

    // Reset lands in the off gap with the full count loaded
    wait_timer #(
        .W(W),
        .RESET_COUNT(OFF_GAP_CYCLES[W-1:0])
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(timer_load),
        .load_value(timer_value),
        .tick(timer_tick),
        .expired(timer_done)
    );

    // Reference clock divider, running only once rails are settled
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            div_count <= 16'h0000;
            external_reference_clock <= 1'b0;
            refclk_rise <= 1'b0;
        end else if (!clock_run) begin
            div_count <= 16'h0000;
            external_reference_clock <= 1'b0;
            refclk_rise <= 1'b0;
        end else if (div_count == HALF_LAST) begin
            div_count <= 16'h0000;
            external_reference_clock <= ~external_reference_clock;
            refclk_rise <= ~external_reference_clock;
        end else begin
            div_count <= div_count + 16'h0001;
            refclk_rise <= 1'b0;
        end
    end

    // A new wait is loaded on every state change
    assign timer_load = (next_state != state);

    always @* begin
        timer_tick = 1'b1;
        case (next_state)
            S_OFF_GAP: timer_value = OFF_GAP_CYCLES[W-1:0];
            S_PLL_ON: timer_value = RAIL_ON_GAP_CYCLES[W-1:0];
            S_ANA_ON: timer_value = RAIL_ON_GAP_CYCLES[W-1:0];
            S_CORE_ON: timer_value = RAIL_ON_GAP_CYCLES[W-1:0];
            S_IO_ON: timer_value = RAIL_ON_GAP_CYCLES[W-1:0];
            S_SER_ON: timer_value = RAIL_ON_GAP_CYCLES[W-1:0];
            S_RESET: timer_value = RESET_HOLD_CYCLES[W-1:0];
            S_INIT: timer_value = INIT_REFCLKS[W-1:0];
            S_PLL_LOCK: timer_value = PLL_LOCK_CYCLES[W-1:0];
            S_STANDBY: timer_value = STANDBY_WAIT_CYCLES[W-1:0];
            S_SER_OFF: timer_value = `RAIL_OFF_GAP_CYCLES;
            S_IO_OFF: timer_value = `RAIL_OFF_GAP_CYCLES;
            S_CORE_OFF: timer_value = `RAIL_OFF_GAP_CYCLES;
            S_ANA_OFF: timer_value = `RAIL_OFF_GAP_CYCLES;
            S_PLL_OFF: timer_value = `RAIL_OFF_GAP_CYCLES;
            default: timer_value = {W{1'b0}};
        endcase
        // Initialisation counts reference clock rising edges, not system cycles
        if (state == S_INIT) begin
            timer_tick = refclk_rise;
        end
    end

    assign ramping_up = (state >= S_PLL_ON) && (state <= S_PLL_LOCK);

    always @* begin
        next_state = state;
        case (state)
            S_OFF_GAP: begin
                if (timer_done) begin
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (power_up_req && !power_down_req) begin
                    next_state = S_PLL_ON;
                end
            end
            S_PLL_ON: begin
                if (timer_done) begin
                    next_state = S_ANA_ON;
                end
            end
            S_ANA_ON: begin
                if (timer_done) begin
                    next_state = S_CORE_ON;
                end
            end
            S_CORE_ON: begin
                if (timer_done) begin
                    next_state = S_IO_ON;
                end
            end
            S_IO_ON: begin
                if (timer_done) begin
                    next_state = (USE_SERIAL_RAIL != 0) ? S_SER_ON : S_SETTLE;
                end
            end
            S_SER_ON: begin
                if (timer_done) begin
                    next_state = S_SETTLE;
                end
            end
            S_SETTLE: begin
                if (stable) begin
                    next_state = S_RESET;
                end
            end
            S_RESET: begin
                if (timer_done) begin
                    next_state = S_INIT;
                end
            end
            S_INIT: begin
                if (timer_done) begin
                    next_state = S_CONFIG;
                end
            end
            S_CONFIG: begin
                if (config_done) begin
                    next_state = S_PLL_LOCK;
                end
            end
            S_PLL_LOCK: begin
                if (timer_done) begin
                    next_state = S_STREAM_ON;
                end
            end
            S_STREAM_ON: begin
                if (stream_write_ack) begin
                    next_state = S_STREAMING;
                end
            end
            S_STREAMING: begin
                if (power_down_req) begin
                    next_state = S_STREAM_OFF;
                end
            end
            S_STREAM_OFF: begin
                if (stream_write_ack) begin
                    next_state = S_STANDBY;
                end
            end
            S_STANDBY: begin
                if (timer_done) begin
                    next_state = S_SER_OFF;
                end
            end
            S_SER_OFF: begin
                if (timer_done) begin
                    next_state = S_IO_OFF;
                end
            end
            S_IO_OFF: begin
                if (timer_done) begin
                    next_state = S_CORE_OFF;
                end
            end
            S_CORE_OFF: begin
                if (timer_done) begin
                    next_state = S_ANA_OFF;
                end
            end
            S_ANA_OFF: begin
                if (timer_done) begin
                    next_state = S_PLL_OFF;
                end
            end
            S_PLL_OFF: begin
                if (timer_done) begin
                    next_state = S_OFF_GAP;
                end
            end
            default: begin
                next_state = S_SER_OFF;
            end
        endcase
        // Abort from S_PLL_ON to S_PLL_LOCK, except in S_CONFIG, goes straight to rail removal
        if (ramping_up && power_down_req && state != S_CONFIG) begin
            next_state = S_SER_OFF;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= S_OFF_GAP;
        end else begin
            state <= next_state;
        end
    end

    // Pin and handshake outputs follow the next state so they move with it
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pll_supply_rail_en <= 1'b0;
            analog_supply_rail_en <= 1'b0;
            pixel_array_supply_rail_en <= 1'b0;
            core_supply_rail_en <= 1'b0;
            io_supply_rail_en <= 1'b0;
            serial_output_supply_rail_en <= 1'b0;
            clock_run <= 1'b0;
            sensor_reset_n <= 1'b0;
            config_req <= 1'b0;
            stream_write_req <= 1'b0;
            stream_enable_bit <= 1'b0;
            streaming <= 1'b0;
            powered_off <= 1'b1;
            sequence_state <= S_OFF_GAP;
        end else begin
            sequence_state <= next_state;
            powered_off <= (next_state == S_OFF_GAP) || (next_state == S_IDLE);
            streaming <= (next_state == S_STREAMING);
            config_req <= (next_state == S_CONFIG);
            stream_write_req <= (next_state == S_STREAM_ON) || (next_state == S_STREAM_OFF);
            if (next_state == S_STREAM_ON) begin
                stream_enable_bit <= 1'b1;
            end else if (next_state == S_STREAM_OFF) begin
                stream_enable_bit <= 1'b0;
            end
            case (next_state)
                S_PLL_ON: pll_supply_rail_en <= 1'b1;
                S_ANA_ON: begin
                    analog_supply_rail_en <= 1'b1;
                    pixel_array_supply_rail_en <= 1'b1;
                end
                S_CORE_ON: core_supply_rail_en <= 1'b1;
                S_IO_ON: io_supply_rail_en <= 1'b1;
                S_SER_ON: serial_output_supply_rail_en <= 1'b1;
                S_SETTLE: clock_run <= 1'b0;
                S_RESET: clock_run <= 1'b1;
                S_INIT: sensor_reset_n <= 1'b1;
                S_SER_OFF: begin
                    serial_output_supply_rail_en <= 1'b0;
                    sensor_reset_n <= 1'b0;
                    clock_run <= 1'b0;
                end
                S_IO_OFF: io_supply_rail_en <= 1'b0;
                S_CORE_OFF: core_supply_rail_en <= 1'b0;
                S_ANA_OFF: begin
                    analog_supply_rail_en <= 1'b0;
                    pixel_array_supply_rail_en <= 1'b0;
                end
                S_PLL_OFF: pll_supply_rail_en <= 1'b0;
                default: begin
                end
            endcase
        end
    end
endmodule

/* File: dv/sensor_power_sequencer_chk.sv */
// Port assertions for the sensor power sequencer
`timescale 1ns/1ns
module sensor_power_sequencer_chk #(
    parameter RAIL_ON_GAP_CYCLES = 5,
    parameter RESET_HOLD_CYCLES = 20,
    parameter INIT_REFCLKS = 10,
    parameter PLL_LOCK_CYCLES = 20,
    parameter OFF_GAP_CYCLES = 30
) (
    input wire clk_sys,
    input wire rst_n,
    input wire rails_stable,
    input wire pll_supply_rail_en,
    input wire analog_supply_rail_en,
    input wire pixel_array_supply_rail_en,
    input wire core_supply_rail_en,
    input wire io_supply_rail_en,
    input wire serial_output_supply_rail_en,
    input wire external_reference_clock,
    input wire sensor_reset_n,
    input wire config_req,
    input wire stream_write_req,
    input wire stream_enable_bit,
    input wire streaming,
    input wire [4:0] sequence_state
);
    localparam int GAP = RAIL_ON_GAP_CYCLES + 1;
    localparam int LOCK = PLL_LOCK_CYCLES;
    localparam int OFFD = OFF_GAP_CYCLES;
    reg [31:0] hold_cnt;
    reg [31:0] ref_cnt;
    reg ref_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Cycles spent in the reset hold, reference clock rises after release
    always @(posedge clk_sys) begin
        ref_q <= external_reference_clock;
        if (!rst_n || sequence_state != 5'h08)
            hold_cnt <= 32'h00000000;
        else
            hold_cnt <= hold_cnt + 32'h00000001;
        if (!rst_n || !sensor_reset_n)
            ref_cnt <= 32'h00000000;
        else if (external_reference_clock && !ref_q)
            ref_cnt <= ref_cnt + 32'h00000001;
    end
    sequence s_ramp;
        ##GAP ($rose(analog_supply_rail_en) && $rose(pixel_array_supply_rail_en))
        ##GAP $rose(core_supply_rail_en) ##GAP $rose(io_supply_rail_en);
    endsequence
    sequence s_teardown;
        ##2 $fell(core_supply_rail_en)
        ##2 ($fell(analog_supply_rail_en) && $fell(pixel_array_supply_rail_en))
        ##2 $fell(pll_supply_rail_en);
    endsequence
    a_pll_rail_first: assert property ((analog_supply_rail_en || pixel_array_supply_rail_en ||
        core_supply_rail_en || io_supply_rail_en || serial_output_supply_rail_en)
        |-> pll_supply_rail_en) else $error("rail on without pll rail");
    a_ramp_order: assert property ($rose(pll_supply_rail_en) |-> s_ramp)
        else $error("rail ramp order or spacing wrong");
    a_clock_after_rails: assert property (external_reference_clock
        |-> io_supply_rail_en && rails_stable) else $error("clock before rails stable");
    a_reset_hold_len: assert property ($rose(sensor_reset_n)
        |-> hold_cnt >= RESET_HOLD_CYCLES) else $error("reset hold too short");
    a_init_wait: assert property ($rose(config_req) |-> ref_cnt >= INIT_REFCLKS)
        else $error("config before init count");
    a_config_standby: assert property (config_req
        |-> sensor_reset_n && !stream_write_req && !streaming) else $error("config not in standby");
    a_lock_wait: assert property ($fell(config_req) |-> (!stream_write_req throughout
        ##LOCK 1'b1) ##1 (stream_write_req && stream_enable_bit)) else $error("lock wait wrong");
    a_stream_last: assert property (stream_write_req && stream_enable_bit
        |-> sensor_reset_n && io_supply_rail_en && !config_req) else $error("stream on too early");
    a_stop_first: assert property ($fell(io_supply_rail_en)
        |-> !streaming && !stream_enable_bit) else $error("rails off while streaming");
    a_off_order: assert property ($fell(io_supply_rail_en) |-> s_teardown)
        else $error("rail off order wrong");
    a_off_gap_len: assert property ($fell(pll_supply_rail_en)
        |-> (!pll_supply_rail_en throughout ##OFFD 1'b1)) else $error("power off gap short");
endmodule

bind sensor_power_sequencer sensor_power_sequencer_chk #(
    .RAIL_ON_GAP_CYCLES(RAIL_ON_GAP_CYCLES), .RESET_HOLD_CYCLES(RESET_HOLD_CYCLES),
    .INIT_REFCLKS(INIT_REFCLKS), .PLL_LOCK_CYCLES(PLL_LOCK_CYCLES),
    .OFF_GAP_CYCLES(OFF_GAP_CYCLES)
) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .rails_stable(rails_stable),
    .pll_supply_rail_en(pll_supply_rail_en), .analog_supply_rail_en(analog_supply_rail_en),
    .pixel_array_supply_rail_en(pixel_array_supply_rail_en),
    .core_supply_rail_en(core_supply_rail_en), .io_supply_rail_en(io_supply_rail_en),
    .serial_output_supply_rail_en(serial_output_supply_rail_en),
    .external_reference_clock(external_reference_clock), .sensor_reset_n(sensor_reset_n),
    .config_req(config_req), .stream_write_req(stream_write_req),
    .stream_enable_bit(stream_enable_bit), .streaming(streaming),
    .sequence_state(sequence_state)
);

/* File: dv/image_sensor_model.sv */
// Behavioural image sensor seen from the sequencer pins
`timescale 1ns/1ns
module image_sensor_model #(
    parameter INIT_REFCLKS = 10
) (
    input wire clk_sys,
    input wire [4:0] rails_on,
    input wire external_reference_clock,
    input wire sensor_reset_n,
    input wire config_req,
    input wire stream_write_req,
    input wire stream_enable_bit,
    input wire [2:0] lat,
    output reg rails_stable = 1'b0,
    output reg config_done = 1'b0,
    output reg stream_write_ack = 1'b0,
    output reg standby = 1'b0,
    output reg err = 1'b0
);
    reg [2:0] settle = 3'h0;
    reg [15:0] n_ref = 16'h0000;
    reg [3:0] wait_cnt = 4'h0;
    reg ref_q = 1'b0;
    reg stopping = 1'b0;
    wire all_on = &rails_on;
    wire ref_rise = external_reference_clock && !ref_q;
    always @(posedge clk_sys) begin
        ref_q <= external_reference_clock;
        settle <= {settle[1:0], all_on};
        rails_stable <= all_on && (&settle);
        // Initialisation counts reference clocks after reset release
        if (!sensor_reset_n)
            n_ref <= 16'h0000;
        else if (ref_rise)
            n_ref <= n_ref + 16'h0001;
        if (config_req && n_ref < INIT_REFCLKS)
            err <= 1'b1;
        if (stream_write_req && stream_enable_bit && !(all_on && sensor_reset_n))
            err <= 1'b1;
        // Answers come lat+1 cycles after the request
        wait_cnt <= (config_req || stream_write_req) ? wait_cnt + 4'h1 : 4'h0;
        config_done <= config_req && wait_cnt == {1'b0, lat};
        stream_write_ack <= stream_write_req && wait_cnt == {1'b0, lat};
        if (!all_on) begin
            standby <= 1'b0;
            stopping <= 1'b0;
        end else if (stream_write_ack) begin
            standby <= 1'b0;
            stopping <= !stream_enable_bit;
        end else if (stopping && ref_rise) begin
            standby <= 1'b1;
            stopping <= 1'b0;
        end
    end
endmodule

/* File: dv/sensor_power_sequencer_tb.sv */
// Self-checking bench for the sensor power sequencer
`timescale 1ns/1ns
module sensor_power_sequencer_tb;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg power_up_req = 1'b0;
    reg power_down_req = 1'b0;
    reg [2:0] lat = 3'h1;
    reg [15:0] lfsr = 16'h7ab0;
    reg [4:0] last_state = 5'h00;
    reg [4:0] exp_s;
    wire rails_stable, config_done, stream_write_ack, standby, model_err;
    wire pll, ana, pix, core, io, ser, refclk, sensor_reset_n;
    wire config_req, stream_write_req, stream_enable_bit, streaming, powered_off;
    wire [4:0] sequence_state;
    int n_fail = 0;
    int n_compared = 0;
    int k;
    logic [4:0] exp_q[$];
    always #4 clk_sys = ~clk_sys;

    // Shortened waits so both power cycles fit the run
    localparam int RAIL_GAP = 5, HOLD = 20, REFS = 10, LOCK = 20, SBY = 10, OFFG = 30;

    sensor_power_sequencer #(.RAIL_ON_GAP_CYCLES(RAIL_GAP), .RESET_HOLD_CYCLES(HOLD),
        .INIT_REFCLKS(REFS), .PLL_LOCK_CYCLES(LOCK), .STANDBY_WAIT_CYCLES(SBY),
        .OFF_GAP_CYCLES(OFFG)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .power_up_req(power_up_req),
        .power_down_req(power_down_req), .rails_stable(rails_stable),
        .config_done(config_done), .stream_write_ack(stream_write_ack),
        .pll_supply_rail_en(pll), .analog_supply_rail_en(ana),
        .pixel_array_supply_rail_en(pix), .core_supply_rail_en(core),
        .io_supply_rail_en(io), .serial_output_supply_rail_en(ser),
        .external_reference_clock(refclk), .sensor_reset_n(sensor_reset_n),
        .config_req(config_req), .stream_write_req(stream_write_req),
        .stream_enable_bit(stream_enable_bit), .streaming(streaming),
        .powered_off(powered_off), .sequence_state(sequence_state));

    image_sensor_model #(.INIT_REFCLKS(REFS)) sensor (
        .clk_sys(clk_sys), .rails_on({pll, ana, pix, core, io}),
        .external_reference_clock(refclk), .sensor_reset_n(sensor_reset_n),
        .config_req(config_req), .stream_write_req(stream_write_req),
        .stream_enable_bit(stream_enable_bit), .lat(lat), .rails_stable(rails_stable),
        .config_done(config_done), .stream_write_ack(stream_write_ack),
        .standby(standby), .err(model_err));

    function [15:0] lfsr_next(input [15:0] v);
        lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Rails pll ana pix core io ser, then reset_n, streaming, powered_off
    function [8:0] exp_out(input [4:0] s);
        case (s)
            5'h00, 5'h01: exp_out = 9'h001;
            5'h02, 5'h13: exp_out = 9'h100;
            5'h03, 5'h12: exp_out = 9'h1c0;
            5'h04, 5'h11: exp_out = 9'h1e0;
            5'h05, 5'h07, 5'h08, 5'h10: exp_out = 9'h1f0;
            5'h0d: exp_out = 9'h1f6;
            5'h14: exp_out = 9'h000;
            default: exp_out = 9'h1f4;
        endcase
    endfunction

    task check(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task wait_state(input logic [4:0] s);
        for (k = 0; k < 3000 && sequence_state !== s; k++)
            @(negedge clk_sys);
        if (sequence_state !== s)
            check({4'h0, sequence_state}, {4'h0, s});
    endtask

    task wrap_up;
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Each state change takes the oldest expected state off the queue
    always @(negedge clk_sys) begin
        if (rst_n && sequence_state !== last_state) begin
            exp_s = (exp_q.size() != 0) ? exp_q.pop_front() : 5'h1f;
            check({4'h0, sequence_state}, {4'h0, exp_s});
            check({pll, ana, pix, core, io, ser, sensor_reset_n, streaming, powered_off},
                exp_out(exp_s));
            if (exp_s == 5'h10)
                check({8'h00, standby}, 9'h001);
        end
        last_state <= sequence_state;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        wrap_up;
    end

    initial begin
        exp_q.push_back(5'h01);
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n <= 1'b1;
        power_up_req <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            lfsr = lfsr_next(lfsr);
            lat <= lfsr[2:0];
            exp_q = {exp_q, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h09, 5'h0a,
                5'h0b, 5'h0c, 5'h0d};
            wait_state(5'h0d);
            repeat (lfsr[6:3]) @(negedge clk_sys);
            exp_q = {exp_q, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h00, 5'h01};
            power_down_req <= 1'b1;
            wait_state(5'h0e);
            power_down_req <= 1'b0;
            power_up_req <= (c == 0);
            wait_state(5'h01);
        end
        repeat (4) @(negedge clk_sys);
        check({8'h00, model_err}, 9'h000);
        check(9'(exp_q.size()), 9'h000);
        wrap_up;
    end
endmodule
